/* File: rtl/ioc_pkg.sv */
/*
 * Shared constants, types and field layouts for the internal oscillator
 * clock select block. Assumes a single 25 MHz system clock.
 */
package ioc_pkg;

    // oscillator configuration field encodings of the two internal modes
    localparam logic [3:0] IOC_CFG_INTERNAL_OSC_CLKOUT_MODE = 4'h9;
    localparam logic [3:0] IOC_CFG_INTERNAL_OSC_ALL_IO_MODE = 4'h8;

    // internal frequency select codes
    localparam logic [2:0] IOC_FSEL_8MHZ = 3'h7;
    localparam logic [2:0] IOC_FSEL_4MHZ = 3'h6;
    localparam logic [2:0] IOC_FSEL_31KHZ = 3'h0;

    // postscaler shifts: divide-by-256 low-frequency path and the base of the 7 - code divide
    localparam logic [3:0] IOC_SHIFT_DIV256 = 4'h8;
    localparam logic [3:0] IOC_SHIFT_TOP = 4'h7;

    // oscillator tuning register layout and reset value
    localparam int IOC_TUNE_LFSRC_BIT = 7;
    localparam int IOC_TUNE_MULT_BIT = 6;
    localparam int IOC_TUNE_VAL_LSB = 0;
    localparam int IOC_TUNE_VAL_W = 5;
    localparam logic [7:0] IOC_TUNE_RESET = 8'h00;

    // timing: clock rate and tuning settle figures
    localparam int IOC_CLK_KHZ = 25000;
    localparam int IOC_PRI_SETTLE_US = 1000;
    localparam int IOC_PRI_SETTLE_CYCLES = (IOC_PRI_SETTLE_US * IOC_CLK_KHZ) / 1000;
    localparam int IOC_LP_SETTLE_TICKS = 8;
    localparam int IOC_TUNE_STEPS = 32;

    // which source feeds the device clock
    typedef enum logic [1:0] {
        IOC_SRC_PRIMARY,
        IOC_SRC_POSTSCALE,
        IOC_SRC_LOW_POWER
    } ioc_src_e;

    // one pin: level driven and active-low output enable
    typedef struct packed {
        logic out;
        logic oe_n;
    } ioc_pin_s;

    // supervisory features that keep the low-power oscillator alive
    typedef struct packed {
        logic powerup_timer;
        logic clock_monitor;
        logic watchdog;
        logic two_speed;
    } ioc_feat_s;

    // decoded oscillator tuning register
    typedef struct packed {
        logic low_freq_source_select;
        logic multiplier_enable;
        logic [IOC_TUNE_VAL_W-1:0] tuning_value;
    } ioc_tune_s;

endpackage

/* File: rtl/ioc_postscaler.sv */
/*
 * Postscaler for the primary internal clock: passes one tick out of
 * every 2**shift_in input ticks. Assumes ticks synchronous to clk_sys_in.
 */
`timescale 1ns/10ps
module ioc_postscaler
    import ioc_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic tick_in,
    input wire logic [3:0] shift_in,
    output logic tick_out
);
    logic [7:0] count_reg;
    logic [7:0] last_val;
    logic [8:0] span;

    // terminal count is 2**shift - 1, shift 8 gives the divide-by-256
    assign span = (9'h001 << shift_in) - 9'h001;
    assign last_val = span[7:0];

    // count primary ticks and emit one registered tick per period
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_reg <= 8'h00;
            tick_out <= 1'b0;
        end else if (tick_in) begin
            if (count_reg >= last_val) begin
                count_reg <= 8'h00;
                tick_out <= 1'b1;
            end else begin
                count_reg <= count_reg + 8'h01;
                tick_out <= 1'b0;
            end
        end else begin
            tick_out <= 1'b0;
        end
    end

endmodule

/* File: rtl/ioc_internal_osc_ctrl.sv */
/*
 * Control logic of the internal oscillator block: source selection,
 * postscaling, multiplier gating, tuning slew and oscillator pin reuse.
 * Assumes oscillator ticks and pin inputs are synchronous to clk_sys_in;
 * the analog oscillators and multiplier sit outside and obey the
 * enable and trim outputs.
 */
`timescale 1ns/10ps
module ioc_internal_osc_ctrl
    import ioc_pkg::*;
#(
    parameter int PRI_SETTLE_CYCLES = IOC_PRI_SETTLE_CYCLES
)
(
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic [3:0] oscillator_config_field_in,
    input wire logic [2:0] internal_freq_select_in,
    input wire logic tune_wr_in,
    input wire logic [7:0] tune_wdata_in,
    output logic [7:0] tune_rdata_out,
    input wire ioc_feat_s feat_in,
    input wire logic primary_tick_in,
    input wire logic low_power_tick_in,
    output logic primary_osc_en_out,
    output logic low_power_osc_en_out,
    output ioc_src_e clk_src_out,
    output logic device_clk_tick_out,
    output logic multiplier_run_out,
    output logic [4:0] primary_trim_out,
    output logic [4:0] low_power_trim_out,
    output logic internal_osc_mode_out,
    input wire logic osc_pin_one_in,
    output ioc_pin_s osc_pin_one_out,
    input wire logic osc_pin_two_in,
    output ioc_pin_s osc_pin_two_out,
    input wire ioc_pin_s port_a_bit7_ctl_in,
    input wire ioc_pin_s port_a_bit6_ctl_in,
    output logic port_a_bit7_pin_out,
    output logic port_a_bit6_pin_out
);
    // one trim code per step interval: 31 codes fit in the
    // settle allowance; a small override shortens the interval
    // for quick runs, and the floor of one keeps it counting
    localparam int STEP_CYCLES_I = PRI_SETTLE_CYCLES / IOC_TUNE_STEPS;
    localparam logic [15:0] STEP_CYCLES =
        16'((STEP_CYCLES_I < 1) ? 1 : STEP_CYCLES_I);

    // reset synchroniser pair
    logic rst_meta_reg;
    logic rst_n;

    // stored tuning state, trims and step counter
    ioc_tune_s tune_reg;
    logic [4:0] pri_trim_reg;
    logic [4:0] lp_trim_reg;
    logic lp_pending_reg;
    logic [15:0] step_cnt_reg;

    // decode and device tick path
    logic cfg_clkout;
    logic cfg_allio;
    logic cfg_internal;
    logic fsel_fast;
    logic lf_path;
    ioc_src_e src_next;
    logic [3:0] shift_next;
    logic post_tick;
    logic tick_next;
    logic [1:0] fosc_phase_reg;
    logic fosc_div4_reg;

    // signed views: 11111 sits just below centre
    logic signed [4:0] pri_now;
    logic signed [4:0] pri_goal;

    // reset release through two flops; assertion is immediate,
    // release waits two edges so no flop leaves reset a cycle
    // ahead of its neighbours
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // configuration decode of the two internal-oscillator pin modes
    // any other code hands the pins to other oscillator logic
    assign cfg_clkout = (oscillator_config_field_in == IOC_CFG_INTERNAL_OSC_CLKOUT_MODE);
    assign cfg_allio = (oscillator_config_field_in == IOC_CFG_INTERNAL_OSC_ALL_IO_MODE);
    assign cfg_internal = cfg_clkout | cfg_allio;
    assign internal_osc_mode_out = cfg_internal;

    // only 8 MHz and 4 MHz selections may feed the multiplier
    // exact code compare, so no other code can arm it
    assign fsel_fast = (internal_freq_select_in == IOC_FSEL_8MHZ) ||
                       (internal_freq_select_in == IOC_FSEL_4MHZ);

    // low-frequency option taken from the primary clock divided by 256
    // when the stored select bit is set, else the low-power clock
    assign lf_path = tune_reg.low_freq_source_select;

    // tuning register: the multiplier bit only holds a one where usable,
    // so an unusable multiplier cannot be armed behind software's back
    // every field is taken at once; there are no partial writes
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            tune_reg.low_freq_source_select <= IOC_TUNE_RESET[IOC_TUNE_LFSRC_BIT];
            tune_reg.multiplier_enable <= IOC_TUNE_RESET[IOC_TUNE_MULT_BIT];
            tune_reg.tuning_value <= IOC_TUNE_RESET[IOC_TUNE_VAL_LSB +: IOC_TUNE_VAL_W];
        end else if (tune_wr_in) begin
            tune_reg.low_freq_source_select <= tune_wdata_in[IOC_TUNE_LFSRC_BIT];
            tune_reg.multiplier_enable <=
                tune_wdata_in[IOC_TUNE_MULT_BIT] & cfg_internal;
            tune_reg.tuning_value <=
                tune_wdata_in[IOC_TUNE_VAL_LSB +: IOC_TUNE_VAL_W];
        end else if (!cfg_internal) begin
            tune_reg.multiplier_enable <= 1'b0;
        end
    end

    // read back: bit 5 unimplemented, multiplier bit masked where unusable;
    // no completion flag exists, software simply sees the written value
    // rebuilt every cycle, so a mode change masks bit 6 one edge later
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            tune_rdata_out <= 8'h00;
        end else begin
            tune_rdata_out <= 8'h00;
            tune_rdata_out[IOC_TUNE_LFSRC_BIT] <= tune_reg.low_freq_source_select;
            tune_rdata_out[IOC_TUNE_MULT_BIT] <=
                tune_reg.multiplier_enable & cfg_internal;
            tune_rdata_out[IOC_TUNE_VAL_LSB +: IOC_TUNE_VAL_W] <= tune_reg.tuning_value;
        end
    end

    // multiplier runs only when all three conditions hold;
    // the request is registered so decode glitches never
    // reach the analog loop, at the cost of one cycle
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            multiplier_run_out <= 1'b0;
        end else begin
            multiplier_run_out <= tune_reg.multiplier_enable & cfg_internal
                                  & fsel_fast;
        end
    end

    // oscillator enables: primary for 125 kHz..8 MHz or the divided
    // low-frequency path; low-power when chosen or a feature needs it
    // both are registered for the same glitch reason
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            primary_osc_en_out <= 1'b0;
            low_power_osc_en_out <= 1'b0;
        end else begin
            primary_osc_en_out <= (internal_freq_select_in != IOC_FSEL_31KHZ)
                                  || lf_path;
            low_power_osc_en_out <= ((internal_freq_select_in == IOC_FSEL_31KHZ)
                                     && !lf_path)
                                    || feat_in.powerup_timer
                                    || feat_in.clock_monitor
                                    || feat_in.watchdog
                                    || feat_in.two_speed;
        end
    end

    // source selection from the frequency select field
    // codes 6 down to 1 halve the rate per step below 8 MHz;
    // code 0 is the slow option, split by the select bit
    always_comb begin
        src_next = IOC_SRC_POSTSCALE;
        shift_next = 4'h0;
        case (internal_freq_select_in)
            IOC_FSEL_8MHZ: begin
                src_next = IOC_SRC_PRIMARY;
            end
            IOC_FSEL_31KHZ: begin
                if (lf_path) begin
                    src_next = IOC_SRC_POSTSCALE;
                    shift_next = IOC_SHIFT_DIV256;
                end else begin
                    src_next = IOC_SRC_LOW_POWER;
                end
            end
            default: begin
                // 4 MHz down to 125 kHz: divide by 2**(7 - code)
                src_next = IOC_SRC_POSTSCALE;
                shift_next = IOC_SHIFT_TOP - {1'b0, internal_freq_select_in};
            end
        endcase
    end

    // the postscaler sees the selection directly; its count restarts
    // only on wrap, so a change of divide takes effect within one period
    // a zero shift passes every tick; nothing reads it then
    ioc_postscaler u_postscaler (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n),
        .tick_in(primary_tick_in),
        .shift_in(shift_next),
        .tick_out(post_tick)
    );

    // device clock tick mux; the multiplier itself is analog and is not
    // modelled on the tick grid, its run request goes out separately
    always_comb begin
        case (src_next)
            IOC_SRC_PRIMARY: tick_next = primary_tick_in;
            IOC_SRC_LOW_POWER: tick_next = low_power_tick_in;
            IOC_SRC_POSTSCALE: tick_next = post_tick;
            default: tick_next = 1'b0;
        endcase
    end

    // registered source code and device tick
    // so the tick seen outside is one clean pulse per period
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            clk_src_out <= IOC_SRC_PRIMARY;
            device_clk_tick_out <= 1'b0;
        end else begin
            clk_src_out <= src_next;
            device_clk_tick_out <= tick_next;
        end
    end

    // low-power trim: a write arms a pending update that lands on the
    // next low-power tick, well inside the eight-tick allowance
    // limitation: with the low-power oscillator stopped it waits
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            lp_trim_reg <= 5'h00;
            lp_pending_reg <= 1'b0;
        end else begin
            if (low_power_tick_in && lp_pending_reg) begin
                lp_trim_reg <= tune_reg.tuning_value;
            end
            // a write in the same cycle as the tick keeps the request
            if (tune_wr_in) begin
                lp_pending_reg <= 1'b1;
            end else if (low_power_tick_in) begin
                lp_pending_reg <= 1'b0;
            end
        end
    end
    assign low_power_trim_out = lp_trim_reg;

    // primary trim slews one code per step interval toward the target;
    // the full 31-code span fits inside the settle time, and slewing
    // rather than jumping keeps the running clock free of glitches
    assign pri_now = pri_trim_reg;
    assign pri_goal = tune_reg.tuning_value;

    // step interval counter; a write restarts it so the first
    // move lands a full interval after the new value is stored
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            step_cnt_reg <= 16'h0000;
        end else if (tune_wr_in) begin
            step_cnt_reg <= 16'h0000;
        end else if (step_cnt_reg >= STEP_CYCLES - 16'h0001) begin
            step_cnt_reg <= 16'h0000;
        end else begin
            step_cnt_reg <= step_cnt_reg + 16'h0001;
        end
    end

    // one code per interval toward the target; the trim holds in
    // a write cycle and moves toward the new target next interval
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            pri_trim_reg <= 5'h00;
        end else if (!tune_wr_in && (step_cnt_reg >= STEP_CYCLES - 16'h0001)) begin
            // signed compare: 11111 is one below centre
            if (pri_now < pri_goal) begin
                pri_trim_reg <= pri_trim_reg + 5'h01;
            end else if (pri_now > pri_goal) begin
                pri_trim_reg <= pri_trim_reg - 5'h01;
            end
        end
    end
    assign primary_trim_out = pri_trim_reg;

    // Fosc/4 on the device tick grid: toggle every second tick;
    // limitation: with the multiplier running the true rate is 4x the
    // tick rate, which this grid cannot show
    // the phase runs in every mode, so the pin may start mid-phase
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            fosc_phase_reg <= 2'h0;
            fosc_div4_reg <= 1'b0;
        end else if (device_clk_tick_out) begin
            fosc_phase_reg <= fosc_phase_reg + 2'h1;
            if (fosc_phase_reg[0]) begin
                fosc_div4_reg <= ~fosc_div4_reg;
            end
        end
    end

    // pin one: port bit 7 in both internal modes, released otherwise
    // outside the internal modes other logic owns the pin
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            osc_pin_one_out <= '{out: 1'b0, oe_n: 1'b1};
        end else if (cfg_internal) begin
            osc_pin_one_out <= port_a_bit7_ctl_in;
        end else begin
            osc_pin_one_out <= '{out: 1'b0, oe_n: 1'b1};
        end
    end

    // pin two: Fosc/4 in clock-out mode, port bit 6 in all-io mode
    // the copy lags the device tick by two edges
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            osc_pin_two_out <= '{out: 1'b0, oe_n: 1'b1};
        end else if (cfg_clkout) begin
            osc_pin_two_out <= '{out: fosc_div4_reg, oe_n: 1'b0};
        end else if (cfg_allio) begin
            osc_pin_two_out <= port_a_bit6_ctl_in;
        end else begin
            osc_pin_two_out <= '{out: 1'b0, oe_n: 1'b1};
        end
    end

    // port read side: pin levels where the pin is a port bit, else 0
    // a 0 elsewhere keeps stale pin levels out of port reads
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            port_a_bit7_pin_out <= 1'b0;
            port_a_bit6_pin_out <= 1'b0;
        end else begin
            port_a_bit7_pin_out <= cfg_internal & osc_pin_one_in;
            port_a_bit6_pin_out <= cfg_allio & osc_pin_two_in;
        end
    end

endmodule

/* File: dv/ioc_internal_osc_ctrl_props.sv */
/*
 * Port checker for the oscillator control top: source choice, multiplier
 * gating, supervisory enable and pin reuse. Assumes one clock domain.
 */
`timescale 1ns/10ps
module ioc_osc_props
    import ioc_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic [3:0] oscillator_config_field_in,
    input wire logic [2:0] internal_freq_select_in,
    input wire logic [7:0] tune_rdata_out,
    input wire ioc_feat_s feat_in,
    input wire logic low_power_tick_in,
    input wire logic primary_osc_en_out,
    input wire logic low_power_osc_en_out,
    input wire ioc_src_e clk_src_out,
    input wire logic device_clk_tick_out,
    input wire logic multiplier_run_out,
    input wire logic internal_osc_mode_out,
    input wire ioc_pin_s osc_pin_one_out,
    input wire ioc_pin_s osc_pin_two_out,
    input wire ioc_pin_s port_a_bit7_ctl_in,
    input wire ioc_pin_s port_a_bit6_ctl_in
);
    logic [1:0] up_cnt;
    logic ready;
    logic lp_sel;
    logic post_sel;
    logic ext_mode;
    logic slow_sel;

    // outputs follow inputs only from the third edge after release
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            up_cnt <= 2'h0;
        end else if (up_cnt != 2'h3) begin
            up_cnt <= up_cnt + 2'h1;
        end
    end

    // decoded selections, kept as signals so $past sees plain values
    assign ready = (up_cnt == 2'h3);
    assign lp_sel = (internal_freq_select_in == 3'h0) && !tune_rdata_out[7];
    assign post_sel = (internal_freq_select_in inside {[3'h1:3'h6]});
    assign ext_mode = !internal_osc_mode_out;
    assign slow_sel = (internal_freq_select_in < 3'h6);

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!resetn_in);

    a_mult_fsel_gate: assert property (
        ready && slow_sel && $past(slow_sel) |-> !multiplier_run_out)
        else $error("multiplier runs at a low frequency select");
    a_mult_mode_gate: assert property (
        ready && ext_mode && $past(ext_mode) && $past(ext_mode, 2)
        |-> !multiplier_run_out && !tune_rdata_out[6])
        else $error("multiplier alive outside internal modes");
    a_lp_feat_on: assert property (
        ready && (feat_in != 4'h0) && ($past(feat_in) != 4'h0) |-> low_power_osc_en_out)
        else $error("low-power oscillator off with a feature enabled");
    a_src_low_power: assert property (
        ready && lp_sel && $past(lp_sel)
        |-> clk_src_out == IOC_SRC_LOW_POWER && low_power_osc_en_out)
        else $error("low-power source not chosen");
    a_lp_tick_pass: assert property (
        ready && lp_sel && $past(lp_sel) && $past(lp_sel, 2)
        |-> device_clk_tick_out == $past(low_power_tick_in))
        else $error("low-power tick not passed after one edge");
    a_src_primary: assert property (
        ready && internal_freq_select_in == 3'h7 && $past(internal_freq_select_in) == 3'h7
        |-> clk_src_out == IOC_SRC_PRIMARY && primary_osc_en_out)
        else $error("primary direct source not chosen");
    a_src_postscale: assert property (
        ready && post_sel && $past(post_sel)
        |-> clk_src_out == IOC_SRC_POSTSCALE && primary_osc_en_out)
        else $error("postscaled source or primary enable wrong");
    a_bit5_zero: assert property (tune_rdata_out[5] == 1'b0)
        else $error("unimplemented tuning bit reads one");
    a_pin_clkout: assert property (
        ready && oscillator_config_field_in == 4'h9 && $past(oscillator_config_field_in) == 4'h9
        |-> !osc_pin_two_out.oe_n && osc_pin_one_out == $past(port_a_bit7_ctl_in))
        else $error("clock-out pin mode wrong");
    a_pin_all_io: assert property (
        ready && oscillator_config_field_in == 4'h8 && $past(oscillator_config_field_in) == 4'h8
        |-> osc_pin_two_out == $past(port_a_bit6_ctl_in))
        else $error("pin two does not follow port bit 6");
endmodule

bind ioc_internal_osc_ctrl ioc_osc_props u_props (
    .clk_sys_in, .resetn_in, .oscillator_config_field_in, .internal_freq_select_in,
    .tune_rdata_out, .feat_in, .low_power_tick_in, .primary_osc_en_out,
    .low_power_osc_en_out, .clk_src_out, .device_clk_tick_out, .multiplier_run_out,
    .internal_osc_mode_out, .osc_pin_one_out, .osc_pin_two_out, .port_a_bit7_ctl_in,
    .port_a_bit6_ctl_in
);

/* File: dv/ioc_internal_osc_ctrl_tb.sv */
/*
 * Self-checking bench for the oscillator control block.
 * Assumes the checker is bound in; oscillator ticks come from the bench.
 */
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("[ERR] %s exp %0h got %0h", nm, exp, got); \
    end \
end
module ioc_internal_osc_ctrl_tb
    import ioc_pkg::*;
;
    localparam int PSC = 320;
    logic clk_sys_in, resetn_in, tune_wr_in, pri_tick, lp_tick, pin1_in, pin2_in;
    logic [3:0] cfg;
    logic [2:0] fsel;
    logic [7:0] wdata, rdata;
    ioc_feat_s feat;
    ioc_pin_s p1o, p2o, b7c, b6c;
    logic pen, lpen, dtick, mrun, imode, b7p, b6p, prev2;
    ioc_src_e src;
    logic [4:0] ptrim, ltrim;
    int mismatches, tests_run, tick_cnt, tog_cnt, n0, n1;

    ioc_internal_osc_ctrl #(.PRI_SETTLE_CYCLES(PSC)) dut (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .oscillator_config_field_in(cfg), .internal_freq_select_in(fsel),
        .tune_wr_in(tune_wr_in), .tune_wdata_in(wdata), .tune_rdata_out(rdata),
        .feat_in(feat), .primary_tick_in(pri_tick), .low_power_tick_in(lp_tick),
        .primary_osc_en_out(pen), .low_power_osc_en_out(lpen), .clk_src_out(src),
        .device_clk_tick_out(dtick), .multiplier_run_out(mrun),
        .primary_trim_out(ptrim), .low_power_trim_out(ltrim),
        .internal_osc_mode_out(imode), .osc_pin_one_in(pin1_in), .osc_pin_one_out(p1o),
        .osc_pin_two_in(pin2_in), .osc_pin_two_out(p2o), .port_a_bit7_ctl_in(b7c),
        .port_a_bit6_ctl_in(b6c), .port_a_bit7_pin_out(b7p), .port_a_bit6_pin_out(b6p)
    );

    // 25 MHz clock
    initial begin
        clk_sys_in = 1'b0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end

    // device ticks and pin-two edges, counted for the rate checks
    always @(posedge clk_sys_in) begin
        if (dtick === 1'b1) tick_cnt++;
        if (p2o.out !== prev2) tog_cnt++;
        prev2 = p2o.out;
    end

    task automatic step(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask

    // one-cycle write strobe, returns once read-back has landed
    task automatic wr(input logic [7:0] d);
        tune_wr_in = 1'b1;
        wdata = d;
        step(1);
        tune_wr_in = 1'b0;
        step(2);
    endtask

    // oscillator ticks spaced two cycles apart
    task automatic tick(input int n, input logic lp);
        repeat (n) begin
            if (lp) lp_tick = 1'b1; else pri_tick = 1'b1;
            step(1);
            lp_tick = 1'b0;
            pri_tick = 1'b0;
            step(1);
        end
    endtask

    task automatic t_divide();
        cfg = 4'h9;
        wr(8'h80);
        fsel = 3'h0;
        step(3);
        n0 = tick_cnt;
        tick(255, 1'b0);
        step(3);
        `CHK("div255", 0, tick_cnt - n0)
        tick(1, 1'b0);
        step(3);
        `CHK("div256", 1, tick_cnt - n0)
        wr(8'h00);
        n0 = tick_cnt;
        tick(4, 1'b1);
        step(3);
        `CHK("lp ticks", 4, tick_cnt - n0)
    endtask

    task automatic t_src();
        ioc_src_e es;
        for (int f = 0; f < 8; f++) begin
            for (int s = 0; s < 2; s++) begin
                wr({s[0], 7'h00});
                fsel = f[2:0];
                step(2);
                es = (f == 7) ? IOC_SRC_PRIMARY : (f == 0 && s == 0) ? IOC_SRC_LOW_POWER
                    : IOC_SRC_POSTSCALE;
                `CHK("src", es, src)
                `CHK("pri en", (f != 0 || s != 0), pen)
                `CHK("lp en", (f == 0 && s == 0), lpen)
            end
        end
    endtask

    task automatic t_mult();
        for (int c = 0; c < 16; c++) begin
            cfg = c[3:0];
            step(2);
            `CHK("int mode", (c == 8 || c == 9), imode)
            wr(8'h40);
            `CHK("mult bit", (c == 8 || c == 9) ? 8'h40 : 8'h00, rdata)
            for (int f = 0; f < 8; f++) begin
                fsel = f[2:0];
                step(2);
                `CHK("mult run", ((c == 8 || c == 9) && f >= 6), mrun)
            end
        end
        cfg = 4'h8;
        wr(8'h40);
        cfg = 4'h0;
        step(2);
        cfg = 4'h9;
        step(3);
        `CHK("mult forced", 8'h00, rdata)
        `CHK("mult forced run", 1'b0, mrun)
        wr(8'hFF);
        `CHK("rdata ff", 8'hDF, rdata)
        feat = '0;
        fsel = 3'h7;
        for (int i = 0; i < 4; i++) begin
            feat = 4'(1 << i);
            step(2);
            `CHK("feat lp en", 1'b1, lpen)
        end
        feat = '0;
        step(2);
        `CHK("no feat lp en", 1'b0, lpen)
    endtask

    // slow trim moves one code per step; going below zero must step down
    task automatic t_trim();
        wr(8'h00);
        step(PSC + 40);
        wr(8'h03); // raise the clock, as for corrupted data
        `CHK("trim not jumped", 5'h00, ptrim)
        tick(1, 1'b1);
        `CHK("lp trim", 5'h03, ltrim)
        step(PSC + 40);
        `CHK("pri trim", 5'h03, ptrim)
        wr(8'h1E); // lower it, as for framing errors or a fast timer
        step(25);
        `CHK("trim downward", 5'h01, ptrim)
        step(PSC + 40);
        `CHK("trim negative", 5'h1E, ptrim)
    endtask

    task automatic t_pins();
        cfg = 4'h9;
        fsel = 3'h7;
        wr(8'h00);
        n0 = tick_cnt;
        n1 = tog_cnt;
        tick(8, 1'b0);
        step(3);
        `CHK("direct ticks", 8, tick_cnt - n0)
        `CHK("fosc4 edges", 4, tog_cnt - n1)
        b7c = '{out: 1'b1, oe_n: 1'b0};
        step(2);
        `CHK("pin one", b7c, p1o)
        cfg = 4'h8;
        b6c = '{out: 1'b1, oe_n: 1'b0};
        pin1_in = 1'b1;
        pin2_in = 1'b1;
        step(3);
        `CHK("pin two", b6c, p2o)
        `CHK("bit7 read", 1'b1, b7p)
        `CHK("bit6 read", 1'b1, b6p)
        cfg = 4'h0;
        step(3);
        `CHK("pin two off", 1'b1, p2o.oe_n)
        `CHK("bit6 off", 1'b0, b6p)
        fsel = 3'h5;
        step(2);
        n0 = tick_cnt;
        tick(8, 1'b0);
        step(3);
        `CHK("div4 ticks", 2, tick_cnt - n0)
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // run budget is a few thousand cycles; this cuts a hang short
    initial begin
        repeat (12000) @(posedge clk_sys_in);
        mismatches++;
        print_verdict();
    end

    initial begin
        {resetn_in, tune_wr_in, pri_tick, lp_tick, pin1_in, pin2_in, prev2} = '0;
        {cfg, fsel, wdata, feat, b7c, b6c} = '0;
        {mismatches, tests_run, tick_cnt, tog_cnt} = '0;
        repeat (3) @(posedge clk_sys_in);
        step(1);
        resetn_in = 1'b1;
        step(4);
        `CHK("rdata reset", IOC_TUNE_RESET, rdata)
        t_divide();
        t_src();
        t_mult();
        t_trim();
        t_pins();
        print_verdict();
    end
endmodule
